// ===== capacitive_touch_status_tb_top.sv
// testbench: registers, events, pins and dma flags of the touch status block
`timescale 1ns/10ps
module capacitive_touch_status_tb_top;
  import cts_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fire = 1'b0;
  logic [LEVEL_W-1:0] lvl = '0;
  cts_sample_t sample_in;
  cts_dma_t dma_in = '0;
  logic [31:0] sense_enable;
  logic irq;
  int fail_count = 0;
  int checks = 0;
  logic [31:0] rnd = 32'hbef7;
  logic [31:0] rd;
  logic [31:0] th;
  logic [19:0] tv;
  logic [19:0] bv;
  logic [19:0] nv;
  logic [4:0] pm;
  logic [7:0] ra [7] = '{OFS_PIN_SELECT, OFS_STATUS, OFS_ENABLE, OFS_DISABLE, OFS_MASK,
    OFS_CLEAR, OFS_ENTRY_FLAGS};
  always #2 pclk = ~pclk;
  cts_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_in(sample_in), .dma_in(dma_in),
    .sense_enable(sense_enable), .irq(irq));
  cts_sensor_model i_sensor (.pclk(pclk), .presetn(presetn), .fire(fire), .level_req(lvl),
    .sample_in(sample_in));
  // next pseudo-random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected pin enables, single or paired
  function automatic logic [31:0] pins(input logic [4:0] m, input logic pair);
    return (32'h1 << m) | ((pair && m != 5'd31) ? (32'h2 << m) : 32'h0);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    check("pslverr", {31'h0, pslverr}, {31'h0, a == 8'hf0});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  // one sample from the partner
  task automatic smp(input logic [19:0] v);
    @(posedge pclk);
    fire <= 1'b1;
    lvl <= v;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  // main sequence; the dma data port is never accessed
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i])
      rchk("reset value", ra[i], 32'h0);
    rchk("unmapped", 8'hf0, 32'h0);
    rnd = lfsr(rnd);
    apb(1'b1, OFS_ENABLE, rnd);
    rchk("mask set", OFS_MASK, {29'h0, rnd[2:0]});
    apb(1'b1, OFS_ENABLE, 32'h0);
    apb(1'b1, OFS_MASK, 32'hffff_ffff);
    rchk("mask hold", OFS_MASK, {29'h0, rnd[2:0]});
    apb(1'b1, OFS_DISABLE, 32'h5);
    rchk("mask drop", OFS_MASK, {29'h0, rnd[2:0] & 3'h2});
    apb(1'b1, OFS_ENABLE, 32'h2);
    for (int d = 0; d < 2; d++)
    begin
      rnd = lfsr(rnd);
      tv = {2'b01, rnd[17:0]};
      bv = d ? tv - 20'h100 : tv + 20'h100;
      nv = d ? tv + 20'h100 : tv - 20'h100;
      th = {3'h0, 5'h02, d[0], 3'h0, tv};
      apb(1'b1, OFS_TOUCH_THRESHOLD, th);
      rchk("touch_threshold", OFS_TOUCH_THRESHOLD, th & 32'hffff_fffc);
      apb(1'b1, OFS_CLEAR, 32'h7);
      smp(bv);
      rchk("one beyond", OFS_STATUS, 32'h1);
      rchk("level", OFS_LEVEL, {12'h0, bv});
      rchk("raw", OFS_RAW, {12'h0, bv});
      rchk("idle", OFS_IDLE, {12'h0, bv});
      check("irq masked", {31'h0, irq}, 32'h0);
      smp(bv);
      rchk("entry", OFS_STATUS, 32'h3);
      check("irq entry", {31'h0, irq}, 32'h1);
      apb(1'b1, OFS_CLEAR, 32'h0);
      rchk("clear zero", OFS_STATUS, 32'h3);
      apb(1'b1, OFS_CLEAR, 32'h7);
      rchk("cleared", OFS_STATUS, 32'h0);
      check("irq cleared", {31'h0, irq}, 32'h0);
      smp(nv);
      smp(nv);
      rchk("release", OFS_STATUS, 32'h5);
    end
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      pm = (i == 7) ? 5'd31 : rnd[4:0];
      apb(1'b1, OFS_CONTROL, {31'h0, i[0]});
      apb(1'b1, OFS_PIN_SELECT, {rnd[31:5], pm});
      rchk("pin index", OFS_PIN_SELECT, {27'h0, pm});
      check("pins", sense_enable, pins(pm, i[0]));
    end
    apb(1'b1, OFS_CONTROL, 32'h2);
    apb(1'b1, OFS_DISABLE, 32'h7);
    apb(1'b1, OFS_ENABLE, 32'h1);
    apb(1'b1, OFS_TOUCH_THRESHOLD, 32'h0104_0000);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      @(posedge pclk);
      dma_in <= {1'b1, 16'h0, 3'h0, rnd[12:8], 3'h0, rnd[4:0]};
      @(posedge pclk);
      dma_in <= '0;
      smp(20'h41000);
      rchk("entry flag", OFS_ENTRY_FLAGS, 32'h1 << rnd[12:8]);
      check("dma pin", sense_enable, 32'h1 << rnd[4:0]);
      apb(1'b1, OFS_ENTRY_CLEAR, 32'h1 << rnd[12:8]);
      rchk("flag clear", OFS_ENTRY_FLAGS, 32'h0);
      smp(20'h3f000);
    end
    // a sample while ce is low must leave all state frozen
    apb(1'b1, OFS_CLEAR, 32'h7);
    @(posedge pclk);
    ce <= 1'b0;
    smp(20'h41000);
    @(posedge pclk);
    ce <= 1'b1;
    rchk("frozen status", OFS_STATUS, 32'h0);
    rchk("frozen level", OFS_LEVEL, 32'h0003_f000);
    tally_and_finish();
  end
  // watchdog
  initial
  begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule

// ===== cts_pkg.sv
// package: register map, field layout and carrier types of the touch status block
package cts_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_IDLE = 8'h08;
  localparam logic [7:0] OFS_LEVEL = 8'h0c;
  localparam logic [7:0] OFS_RAW = 8'h10;
  localparam logic [7:0] OFS_TOUCH_THRESHOLD = 8'h18;
  localparam logic [7:0] OFS_PIN_SELECT = 8'h1c;
  localparam logic [7:0] OFS_DMA_DATA = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_ENABLE = 8'h28;
  localparam logic [7:0] OFS_DISABLE = 8'h2c;
  localparam logic [7:0] OFS_MASK = 8'h30;
  localparam logic [7:0] OFS_CLEAR = 8'h34;
  localparam logic [7:0] OFS_ENTRY_FLAGS = 8'h40;
  localparam logic [7:0] OFS_ENTRY_CLEAR = 8'h50;
  localparam logic [7:0] WORD_STRIDE = 8'h04;
  // control register bits
  localparam int CTL_PAIRED = 0;
  localparam int CTL_DMA = 1;
  // event bit positions
  localparam int EV_SAMPLE = 0;
  localparam int EV_ENTRY = 1;
  localparam int EV_RELEASE = 2;
  localparam int EV_BITS = 3;
  // threshold register layout
  localparam int TH_FRAC_LSB = 0;
  localparam int TH_FRAC_W = 12;
  localparam int TH_INT_LSB = 12;
  localparam int TH_INT_W = 8;
  localparam int TH_DIR = 23;
  localparam int TH_LEN_LSB = 24;
  localparam int TH_LEN_W = 5;
  localparam int LEVEL_W = TH_INT_W + TH_FRAC_W;
  localparam int IDLE_W = 28;
  // dma configuration word layout
  localparam int DC_PIN_LSB = 0;
  localparam int DC_SEL_LSB = 8;
  localparam int DC_SEL_W = 8;
  // reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // one new measurement from the acquisition engine
  typedef struct packed {
    logic valid;
    logic [LEVEL_W-1:0] level;
    logic [31:0] raw;
    logic [IDLE_W-1:0] idle;
  } cts_sample_t;
  // dma word written by the memory transfer engine
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } cts_dma_t;
endpackage

// ===== cts_sensor_model.sv
// partner: acquisition engine delivering one sample per request
`timescale 1ns/10ps
module cts_sensor_model
  import cts_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the bench
  input wire logic fire,
  input wire logic [cts_pkg::LEVEL_W-1:0] level_req,
  // sample towards the block
  output cts_pkg::cts_sample_t sample_in
);
  // one-cycle sample; payload scrambled between samples
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_in <= '0;
    else if (fire)
      sample_in <= {1'b1, level_req, 12'h0, level_req, 8'h0, level_req};
    else
      sample_in <= {1'b0, ~sample_in.level, ~sample_in.raw, ~sample_in.idle};
  end
endmodule

// ===== cts_top.sv
// touch status block: threshold compare, event status, mask and per-config flags
// Function
// - direction bit 0 means touch above threshold, 1 means touch below.
// - threshold is integer plus fraction; unimplemented low fraction bits are absent.
// - outside paired mode, acquisition uses the single pin named by the pin index field.
// - paired mode with index m selects pins m and m plus one; with m on the last pin, that pin stands alone.
// - status bits stay set until a one is written to the clear register.
// - release event sets status bit 2; entry bit 1; sample bit 0.
// - every transition into touched state sets the entry status bit.
// - sample bit sets when level, raw and baseline already hold new values.
// - writing one to enable sets the mask bit; zero leaves it.
// - writing one to disable clears the mask bit; zero does nothing.
// - mask bit one enables its source; mask is read only.
// - one in clear drops status bit and its pending request; zero nothing.
// - in dma mode each config carries a selector naming its entry flag.
// - selector s maps to bit s mod 32 of word s div 32.
// - an entry flag reads one once its config saw an entry event.
// - a one in an entry clear word clears the matching entry flag.
// - entry needs the programmed count of successive samples beyond threshold; release needs as many successive samples not beyond.
// - the filtered relative level is compared against the threshold.
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module cts_top
  import cts_pkg::*;
#(
  parameter int N_PINS = 32,
  parameter int PIN_BITS = 5,
  parameter int N_FLAGS = 32,
  parameter int FRAC_BITS = 10
)
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // acquisition engine and dma engine
  input wire cts_pkg::cts_sample_t sample_in,
  input wire cts_pkg::cts_dma_t dma_in,
  // sensor pin selection and interrupt
  output logic [N_PINS-1:0] sense_enable,
  output logic irq
);
  import cts_pkg::*;

  // word count and implemented-bit masks; other bits read zero
  localparam int N_WORDS = (N_FLAGS + 31) / 32;
  localparam int FR_DROP = TH_FRAC_W - FRAC_BITS;
  localparam logic [TH_FRAC_W-1:0] FRAC_MASK = {TH_FRAC_W{1'b1}} << FR_DROP;
  localparam logic [31:0] TOUCH_THRESHOLD_MASK = 32'h1f8f_f000 | 32'(FRAC_MASK);
  localparam logic [31:0] PIN_MASK = 32'((64'h1 << PIN_BITS) - 64'h1);
  localparam logic [31:0] CTL_MASK = 32'h0000_0003;
  localparam logic [31:0] EV_MASK = 32'h0000_0007;

  // refuse configurations the logic cannot serve
  generate
    if (FRAC_BITS < 0 || FRAC_BITS > TH_FRAC_W || N_PINS < 2 || N_PINS > (1 << PIN_BITS)
        || N_FLAGS < 1 || N_FLAGS > (1 << DC_SEL_W) || PIN_BITS > 8)
    begin : g_bad
      $error("cts_top: unsupported parameter set");
    end
  endgenerate

  // entry words sit below the clear words: they must not overlap
  generate
    if (N_WORDS * int'(WORD_STRIDE) > int'(OFS_ENTRY_CLEAR) - int'(OFS_ENTRY_FLAGS))
    begin : g_bad_words
      $error("cts_top: too many entry flag words");
    end
  endgenerate

  // register state
  logic [31:0] control;
  logic [31:0] touch_threshold;
  logic [PIN_BITS-1:0] sensor_pin_index;
  logic [31:0] dma_data_port;
  logic [EV_BITS-1:0] event_status;
  logic [EV_BITS-1:0] event_mask;
  logic [31:0] touch_entry_flags [N_WORDS];
  logic [LEVEL_W-1:0] level_reg;
  logic [31:0] raw_reg;
  logic [IDLE_W-1:0] idle_reg;
  logic [DC_SEL_W-1:0] flag_selector;
  // touch detection state
  logic touched;
  logic [TH_LEN_W-1:0] run_count;

  // bus decode
  logic access;
  logic wr_fire;
  logic [31:0] wr_data;
  logic [31:0] next_rdata;
  logic next_slverr;
  logic mapped;
  assign access = psel && penable;
  assign wr_fire = ce && access && pready && pwrite;
  assign wr_data = pwdata;

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_fire && (paddr == ofs);
  endfunction

  // threshold fields and comparison
  logic [TH_INT_W-1:0] threshold_integer_part;
  logic [TH_FRAC_W-1:0] threshold_fraction_part;
  logic [LEVEL_W-1:0] thr_value;
  logic dir_below;
  logic [TH_LEN_W-1:0] need_count;
  logic beyond;
  logic run_done;
  logic touch_entry_event;
  logic touch_release_event;
  assign threshold_integer_part = touch_threshold[TH_INT_LSB +: TH_INT_W];
  assign threshold_fraction_part = touch_threshold[TH_FRAC_LSB +: TH_FRAC_W] & FRAC_MASK;
  assign thr_value = {threshold_integer_part, threshold_fraction_part};
  assign dir_below = touch_threshold[TH_DIR];
  // filtered level against threshold, sense chosen by direction
  // a level equal to the threshold is beyond in neither direction
  assign beyond = dir_below ? (sample_in.level < thr_value)
                            : (sample_in.level > thr_value);
  // a zero length still needs one sample
  assign need_count = (touch_threshold[TH_LEN_LSB +: TH_LEN_W] == '0)
                    ? TH_LEN_W'(1) : touch_threshold[TH_LEN_LSB +: TH_LEN_W];
  assign run_done = (run_count + TH_LEN_W'(1)) >= need_count;
  assign touch_entry_event = ce && sample_in.valid && !touched && beyond && run_done;
  assign touch_release_event = ce && sample_in.valid && touched && !beyond && run_done;

  // successive-sample counter toward a state change
  // a sample back on the current side restarts the run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_count <= '0;
    else if (ce && sample_in.valid)
    begin
      if ((touched ^ beyond) && !run_done)
        run_count <= run_count + TH_LEN_W'(1);
      else
        run_count <= '0;
    end
  end

  // touched state
  // entry and release never meet: they need opposite touched states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      touched <= 1'b0;
    else if (touch_entry_event)
      touched <= 1'b1;
    else if (touch_release_event)
      touched <= 1'b0;
  end

  // measurement capture, same edge as the sample flag
  // software reading after the sample bit sees the new values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_reg <= '0;
      raw_reg <= '0;
      idle_reg <= '0;
    end
    else if (ce && sample_in.valid)
    begin
      level_reg <= sample_in.level;
      raw_reg <= sample_in.raw;
      idle_reg <= sample_in.idle;
    end
  end

  // control register: paired mode and dma mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control <= RESET_WORD;
    else if (wr_at(OFS_CONTROL))
      control <= wr_data & CTL_MASK;
  end

  // threshold register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      touch_threshold <= RESET_WORD;
    else if (wr_at(OFS_TOUCH_THRESHOLD))
      touch_threshold <= wr_data & TOUCH_THRESHOLD_MASK;
  end

  // pin index, from software or from a dma configuration block
  // a software write wins over a dma block landing in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sensor_pin_index <= '0;
    else if (wr_at(OFS_PIN_SELECT))
      sensor_pin_index <= wr_data[PIN_BITS-1:0];
    else if (ce && dma_in.valid && control[CTL_DMA])
      sensor_pin_index <= dma_in.data[DC_PIN_LSB +: PIN_BITS];
  end

  // dma data port and the selector carried by each configuration block
  // the memory engine owns this port; a dma word wins over a bus write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_data_port <= RESET_WORD;
      flag_selector <= '0;
    end
    else if (ce && dma_in.valid)
    begin
      dma_data_port <= dma_in.data;
      flag_selector <= dma_in.data[DC_SEL_LSB +: DC_SEL_W];
    end
    else if (wr_at(OFS_DMA_DATA))
      dma_data_port <= wr_data;
  end

  // sensor pin enables: one pin, or a pair in paired mode
  // the pair partner of the last pin does not exist, so that pin stands alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sense_enable <= '0;
    else if (ce)
    begin
      for (int p = 0; p < N_PINS; p++)
      begin
        sense_enable[p] <= (32'(sensor_pin_index) == p)
          || (control[CTL_PAIRED] && (32'(sensor_pin_index) + 1 == p));
      end
    end
  end

  // sticky event status, set wins over a clear in the same cycle
  logic [EV_BITS-1:0] ev_set;
  logic [EV_BITS-1:0] ev_clr;
  assign ev_set[EV_SAMPLE] = ce && sample_in.valid;
  assign ev_set[EV_ENTRY] = touch_entry_event;
  assign ev_set[EV_RELEASE] = touch_release_event;
  assign ev_clr = wr_at(OFS_CLEAR) ? wr_data[EV_BITS-1:0] : '0;

  // status after this cycle, shared by the status flops and the request
  logic [EV_BITS-1:0] next_status;
  assign next_status = ev_set | (event_status & ~ev_clr);

  // status flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_status <= '0;
    else
      event_status <= next_status;
  end

  // mask changes only through enable and disable writes
  // one bus cannot write enable and disable in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_mask <= '0;
    else if (wr_at(OFS_ENABLE))
      event_mask <= event_mask | wr_data[EV_BITS-1:0];
    else if (wr_at(OFS_DISABLE))
      event_mask <= event_mask & ~wr_data[EV_BITS-1:0];
  end

  // interrupt request from masked status
  // a masked source must not pulse the request even for one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(next_status & event_mask);
  end

  // per-configuration entry flags, one generate step per word
  // flags beyond N_FLAGS are not built and read zero
  genvar gw;
  generate
    for (gw = 0; gw < N_WORDS; gw++)
    begin : g_word
      logic [31:0] fset;
      logic [31:0] fclr;
      logic [31:0] fimpl;
      always_comb
      begin
        fset = '0;
        fimpl = '0;
        for (int b = 0; b < 32; b++)
          fimpl[b] = (gw * 32 + b) < N_FLAGS;
        if (touch_entry_event && control[CTL_DMA] && (32'(flag_selector) / 32 == gw))
          fset[flag_selector[4:0]] = 1'b1;
      end
      assign fclr = wr_at(OFS_ENTRY_CLEAR + WORD_STRIDE * 8'(gw)) ? wr_data : '0;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          touch_entry_flags[gw] <= RESET_WORD;
        else
          touch_entry_flags[gw] <= (fset | (touch_entry_flags[gw] & ~fclr)) & fimpl;
      end
    end
  endgenerate

  // read mux and address check
  // write-only registers read zero; unknown offsets raise pslverr
  always_comb
  begin
    next_rdata = '0;
    mapped = 1'b1;
    case (paddr)
      OFS_CONTROL: next_rdata = control;
      OFS_IDLE: next_rdata = 32'(idle_reg);
      OFS_LEVEL: next_rdata = 32'(level_reg);
      OFS_RAW: next_rdata = raw_reg;
      OFS_TOUCH_THRESHOLD: next_rdata = touch_threshold;
      OFS_PIN_SELECT: next_rdata = 32'(sensor_pin_index) & PIN_MASK;
      OFS_DMA_DATA: next_rdata = dma_data_port;
      OFS_STATUS: next_rdata = 32'(event_status) & EV_MASK;
      OFS_MASK: next_rdata = 32'(event_mask) & EV_MASK;
      OFS_ENABLE, OFS_DISABLE, OFS_CLEAR: next_rdata = '0;
      default:
      begin
        mapped = 1'b0;
        for (int w = 0; w < N_WORDS; w++)
        begin
          if (paddr == OFS_ENTRY_FLAGS + WORD_STRIDE * 8'(w))
          begin
            next_rdata = touch_entry_flags[w];
            mapped = 1'b1;
          end
          if (paddr == OFS_ENTRY_CLEAR + WORD_STRIDE * 8'(w))
            mapped = 1'b1;
        end
      end
    endcase
    next_slverr = !mapped;
  end

  // apb answer: one wait state, outputs from flops
  // ce low holds the answer until the clock runs again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      if (access && !pready)
      begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_slverr;
      end
      else
      begin
        pready <= 1'b0;
        prdata <= '0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule

// ===== cts_top_monitor.sv
// checker: port-level assertions of the touch status block
`timescale 1ns/10ps
module cts_top_monitor
  import cts_pkg::*;
#(
  parameter int N_PINS = 32
)
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // engines, pins, interrupt
  input wire cts_pkg::cts_sample_t sample_in,
  input wire cts_pkg::cts_dma_t dma_in,
  input wire logic [N_PINS-1:0] sense_enable,
  input wire logic irq
);
  logic done;
  logic [2:0] mask_m;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed transfer
  assign done = psel && penable && pready && ce;
  // shadow of the event mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_m <= 3'h0;
    else if (done && pwrite && paddr == OFS_ENABLE)
      mask_m <= mask_m | pwdata[2:0];
    else if (done && pwrite && paddr == OFS_DISABLE)
      mask_m <= mask_m & ~pwdata[2:0];
  end
  a_ready_latency: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_upper_zero: assert property (done && !pwrite && (paddr == OFS_STATUS ||
    paddr == OFS_MASK) |-> prdata[31:3] == 29'h0)
    else $error("reserved bits set");
  a_irq_cause: assert property ($rose(irq) |-> $past(sample_in.valid || done) ||
    $past(sample_in.valid || done, 2))
    else $error("irq rose without cause");
  a_clear_irq: assert property ($fell(irq) |-> $past(done && pwrite) ||
    $past(done && pwrite, 2))
    else $error("irq fell without write");
  a_mask_quiet: assert property (mask_m == 3'h0 && $past(mask_m) == 3'h0 |-> !irq)
    else $error("irq while masked");
  a_sample_irq: assert property (sample_in.valid && ce && mask_m[0] |-> ##[1:2] irq)
    else $error("sample irq missing");
  a_pin_pair: assert property ($countones(sense_enable) <= 1 || ($countones(sense_enable) == 2
    && (sense_enable & (sense_enable >> 1)) != '0))
    else $error("bad pin enables");
endmodule

bind cts_top cts_top_monitor #(.N_PINS(N_PINS)) i_monitor (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
  .dma_in(dma_in), .sense_enable(sense_enable), .irq(irq));
